/* File: common/oirc_pkg.sv */
package oirc_pkg;

  // ----------------------------------------------------------------
  // Bus layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00; // Modes and selections
  localparam logic [7:0] OFS_OUT = 8'h04; // Output, relay, polarity
  localparam logic [7:0] OFS_CLR = 8'h08; // Protection clear, write only
  localparam logic [7:0] OFS_STAT = 8'h0c; // Latches and live state
  localparam logic [7:0] OFS_LOG = 8'h10; // Logging enables
  localparam logic [7:0] OFS_VSET = 8'h20; // Voltage, stride 8
  localparam logic [7:0] OFS_ISET = 8'h24; // Current, stride 8
  localparam logic [7:0] OFS_DLY = 8'h60; // Turn-on delay, stride 4
  localparam logic [7:0] STRIDE_SET = 8'h08;
  localparam logic [7:0] STRIDE_DLY = 8'h04;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CT_INH_LSB = 0;
  localparam int CT_PAIR_LSB = 2;
  localparam int CT_TRACK = 4;
  localparam int CT_MINMAX = 5;
  localparam int CT_PON_LSB = 8;
  localparam int OUT_REL_LSB = 8;
  localparam int OUT_POL_LSB = 16;
  localparam int CLR_INH = 8;
  localparam int ST_INH_LAT = 8;
  localparam int ST_INH_LVL = 9;
  localparam int ST_EN_LSB = 16;
  localparam int LOG_V_LSB = 0;
  localparam int LOG_C_LSB = 8;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] INH_LATCHED = 2'h0;
  localparam logic [1:0] INH_LIVE = 2'h1;
  localparam logic [1:0] INH_IGNORED = 2'h2;
  localparam logic [1:0] PAIR_OFF = 2'h0;
  localparam logic [1:0] PAIR_PAR = 2'h1;
  localparam logic [1:0] PAIR_SER = 2'h2;
  localparam logic [3:0] PON_RST = 4'h0; // 1..10 pick slots 0..9
  localparam logic [3:0] PON_LAST = 4'ha;
  localparam logic [15:0] OFF_CURRENT_MA = 16'h0014; // 0.02 A
  localparam logic [15:0] RST_VSET = 16'h0000;
  localparam logic [15:0] RST_ISET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DLY_UNIT_NS = 1000000; // Delay unit, 1 ms
  localparam int DLY_TICK_CYC = DLY_UNIT_NS / CLK_PERIOD_NS;

  // Control register carrier
  typedef struct packed {
    logic [3:0] pon;
    logic minmax;
    logic track;
    logic [1:0] pair;
    logic [1:0] inh_mode;
  } oirc_ctrl_t;

endpackage

/* File: rtl/oirc_top.sv */
`timescale 1ns/1ps
// Contract
// - Stored inhibit mode, three readable codes
// - Inhibit shuts every channel at once
// - Inhibit leaves commanded-off channels alone
// - Inhibit mode kept across power cycles
// - Latched: rise disables until low, cleared
// - Live: enabled outputs follow inhibit level
// - Ignored mode: inhibit input has no effect
// - Power-up applies reset or slot 0-9
// - Protection clear releases listed channel latches
// - Disabled output: zero volts, 0.02 A
// - Relay line moves only on relay command
// - Relay line level set by polarity
// - Relay state resets off, reads 0/1
// - Tracking start copies plus onto minus
// - Tracking mirrors new voltage to other
// - Per-channel current logging enable
// - Global min/max logging enable
// - Per-channel voltage logging enable
// - Turn-on delay applies after protection clear
module oirc_top #(
  parameter int NCH = 2,
  parameter int MS_CYCLES = oirc_pkg::DLY_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [oirc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic inhibit_input,
  input wire logic front_panel_clear,
  input wire logic [NCH-1:0] fault_trip,
  input wire logic [1:0] nv_inhibit_mode_in,
  input wire logic [3:0] nv_pon_sel_in,
  output logic nv_save,
  output logic [1:0] nv_inhibit_mode,
  output logic [3:0] nv_pon_sel,
  output logic setup_default,
  output logic setup_recall,
  output logic [3:0] stored_setup_slot,
  output logic [NCH-1:0] ch_enable,
  output logic [NCH*16-1:0] ch_vprog,
  output logic [NCH*16-1:0] ch_iprog,
  output logic [NCH-1:0] relay_ctrl,
  output logic [NCH-1:0] volt_log_en,
  output logic [NCH-1:0] curr_log_en,
  output logic minmax_logging_enable,
  output logic track_enable,
  output logic [1:0] pair_mode
);

  // ----------------
  // Parameter checks
  // ----------------
  if (NCH < 2 || NCH > 8) begin : g_bad_nch
    $error("oirc_top: NCH must be 2 to 8");
  end
  if (MS_CYCLES < 2) begin : g_bad_ms
    $error("oirc_top: MS_CYCLES must be at least 2");
  end

  localparam int TW = $clog2(MS_CYCLES);

  // ----------------
  // State
  // ----------------
  typedef struct packed {
    logic inh_s1; // Synchroniser first stage
    logic inh_s2; // Synchronised inhibit level
    logic inh_prev; // Previous level for edge detect
    logic inh_lat; // Latched inhibit status
    logic init_done; // Power-up actions done
    oirc_pkg::oirc_ctrl_t ctrl; // Modes and selections
    logic [NCH-1:0] out_on; // Commanded output state
    logic [NCH-1:0] prot; // Protection latch
    logic [NCH-1:0] relay; // Relay state
    logic [NCH-1:0] rpos; // Relay polarity, 1 positive
    logic [NCH-1:0] relay_pin; // Relay control line
    logic [NCH-1:0] vlog; // Voltage logging enables
    logic [NCH-1:0] clog; // Current logging enables
    logic [NCH-1:0] en; // Output actually enabled
    logic [NCH-1:0] arm; // Turn-on delay running
    logic [NCH-1:0][15:0] vset; // Programmed voltage, mV
    logic [NCH-1:0][15:0] iset; // Programmed current, mA
    logic [NCH-1:0][15:0] vprog; // Voltage sent to stage
    logic [NCH-1:0][15:0] iprog; // Current sent to stage
    logic [NCH-1:0][21:0] dly; // Turn-on delay, ms
    logic [NCH-1:0][21:0] cnt; // Delay countdown
    logic [TW-1:0] tick_cnt; // Millisecond prescaler
    logic tick; // Millisecond pulse
    logic nv_save; // Store request pulse
    logic dflt; // Apply default setup pulse
    logic recall; // Recall slot pulse
    logic [3:0] slot; // Slot to recall
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } oirc_state_t;

  oirc_state_t s_reg; // Registered state
  oirc_state_t s_next; // Next state

  // Finds which channel register an address hits, {hit, index}
  function automatic logic [3:0] chan_hit(
    input logic [7:0] a,
    input logic [7:0] base,
    input logic [7:0] stride
  );
    logic [3:0] r;
    r = 4'h0;
    for (int c = 0; c < NCH; c++) begin
      if (a == 8'(base + 8'(c) * stride)) begin
        r = {1'b1, 3'(c)};
      end
    end
    return r;
  endfunction

  // ----------------
  // Next-state logic
  // ----------------
  always_comb begin
    logic wr; // Write taken at this edge
    logic clr_evt; // Inhibit latch clear request
    logic blk; // Inhibit blocks outputs
    logic want; // Channel should be on
    logic hit; // Address decoded
    logic [3:0] hv; // Voltage register hit
    logic [3:0] hi; // Current register hit
    logic [3:0] hd; // Delay register hit
    logic [NCH-1:0] pclr; // Channels to release
    logic [31:0] rd; // Read word
    oirc_pkg::oirc_ctrl_t nc; // Control as written
    wr = psel & penable & s_reg.pready & pwrite;
    clr_evt = front_panel_clear;
    blk = 1'b0;
    want = 1'b0;
    hit = 1'b0;
    hv = chan_hit(paddr, oirc_pkg::OFS_VSET, oirc_pkg::STRIDE_SET);
    hi = chan_hit(paddr, oirc_pkg::OFS_ISET, oirc_pkg::STRIDE_SET);
    hd = chan_hit(paddr, oirc_pkg::OFS_DLY, oirc_pkg::STRIDE_DLY);
    pclr = '0;
    rd = 32'h0000_0000;
    nc = s_reg.ctrl;
    s_next = s_reg;
    // Inhibit synchroniser, first stage read only by the second
    s_next.inh_s1 = inhibit_input;
    s_next.inh_s2 = s_reg.inh_s1;
    s_next.inh_prev = s_reg.inh_s2;
    // Millisecond prescaler for turn-on delays
    if (s_reg.tick_cnt == TW'(MS_CYCLES - 1)) begin
      s_next.tick_cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 1'b1;
      s_next.tick = 1'b0;
    end

    // One-cycle pulses default low
    s_next.nv_save = 1'b0;
    s_next.dflt = 1'b0;
    s_next.recall = 1'b0;
    // First cycle after reset: take stored settings, pick setup
    if (!s_reg.init_done) begin
      s_next.init_done = 1'b1;
      if (nv_inhibit_mode_in <= oirc_pkg::INH_IGNORED) begin
        s_next.ctrl.inh_mode = nv_inhibit_mode_in;
      end
      if (nv_pon_sel_in <= oirc_pkg::PON_LAST) begin
        s_next.ctrl.pon = nv_pon_sel_in;
      end
      if (nv_pon_sel_in == oirc_pkg::PON_RST ||
          nv_pon_sel_in > oirc_pkg::PON_LAST) begin
        s_next.dflt = 1'b1;
      end else begin
        s_next.recall = 1'b1;
        s_next.slot = nv_pon_sel_in - 4'h1;
      end
    end

    // Register writes
    if (wr) begin
      case (paddr)
        oirc_pkg::OFS_CTRL: begin
          nc.inh_mode = pwdata[oirc_pkg::CT_INH_LSB +: 2];
          nc.pair = pwdata[oirc_pkg::CT_PAIR_LSB +: 2];
          nc.track = pwdata[oirc_pkg::CT_TRACK];
          nc.minmax = pwdata[oirc_pkg::CT_MINMAX];
          nc.pon = pwdata[oirc_pkg::CT_PON_LSB +: 4];
          // Out-of-range codes keep the old selection
          if (nc.inh_mode <= oirc_pkg::INH_IGNORED) begin
            s_next.ctrl.inh_mode = nc.inh_mode;
          end
          if (nc.pair <= oirc_pkg::PAIR_SER) begin
            s_next.ctrl.pair = nc.pair;
          end
          if (nc.pon <= oirc_pkg::PON_LAST) begin
            s_next.ctrl.pon = nc.pon;
          end
          s_next.ctrl.minmax = nc.minmax;
          s_next.ctrl.track = nc.track;
          // Tracking turned on: minus magnitude takes plus value
          if (nc.track && !s_reg.ctrl.track) begin
            s_next.vset[1] = s_reg.vset[0];
          end
          // Persist selections held across power cycles
          if (s_next.ctrl.inh_mode != s_reg.ctrl.inh_mode ||
              s_next.ctrl.pon != s_reg.ctrl.pon) begin
            s_next.nv_save = 1'b1;
          end
        end
        oirc_pkg::OFS_OUT: begin
          s_next.out_on = pwdata[NCH-1:0];
          s_next.relay = pwdata[oirc_pkg::OUT_REL_LSB +: NCH];
          s_next.rpos = pwdata[oirc_pkg::OUT_POL_LSB +: NCH];
        end
        oirc_pkg::OFS_CLR: begin
          pclr = pwdata[NCH-1:0];
          clr_evt = clr_evt | pwdata[oirc_pkg::CLR_INH];
        end
        oirc_pkg::OFS_LOG: begin
          s_next.vlog = pwdata[oirc_pkg::LOG_V_LSB +: NCH];
          s_next.clog = pwdata[oirc_pkg::LOG_C_LSB +: NCH];
        end
        default: begin
          // Per-channel registers
          if (hv[3]) begin
            s_next.vset[hv[2:0]] = pwdata[15:0];
            // Tracking mirrors new magnitude to the partner
            if (s_reg.ctrl.track) begin
              s_next.vset[hv[2:0] == 3'h0 ? 1 : 0] = pwdata[15:0];
            end
          end
          if (hi[3]) begin
            s_next.iset[hi[2:0]] = pwdata[15:0];
          end
          if (hd[3]) begin
            s_next.dly[hd[2:0]] = pwdata[21:0];
          end
        end
      endcase
    end
    // Inhibit latch: rise sets it in latched mode, set wins
    if (s_reg.ctrl.inh_mode == oirc_pkg::INH_LATCHED &&
        s_reg.inh_s2 && !s_reg.inh_prev) begin
      s_next.inh_lat = 1'b1;
    end else if (clr_evt && !s_reg.inh_s2) begin
      s_next.inh_lat = 1'b0;
    end
    // Blocking term shared by every channel
    case (s_reg.ctrl.inh_mode)
      oirc_pkg::INH_LATCHED: blk = s_reg.inh_lat;
      oirc_pkg::INH_LIVE: blk = s_reg.inh_s2;
      default: blk = 1'b0;
    endcase
    // Per-channel protection, delay and output programming
    for (int c = 0; c < NCH; c++) begin
      // Fault trip wins over a clear in the same cycle
      if (fault_trip[c]) begin
        s_next.prot[c] = 1'b1;
      end else if (pclr[c]) begin
        s_next.prot[c] = 1'b0;
      end
      // Off channels never see inhibit; blk hits all at once
      want = s_next.out_on[c] & ~s_reg.prot[c] & ~blk;
      if (!want) begin
        s_next.en[c] = 1'b0;
        s_next.arm[c] = 1'b0;
        s_next.cnt[c] = '0;
      end else if (!s_reg.en[c]) begin
        // Every off-to-on change waits the programmed delay
        if (!s_reg.arm[c]) begin
          s_next.arm[c] = 1'b1;
          s_next.cnt[c] = s_reg.dly[c];
        end else if (s_reg.cnt[c] == 22'h000000) begin
          s_next.en[c] = 1'b1;
          s_next.arm[c] = 1'b0;
        end else if (s_reg.tick) begin
          s_next.cnt[c] = s_reg.cnt[c] - 22'h000001;
        end
      end
      // Off means zero volts and small limit, terminals stay on
      if (s_next.en[c]) begin
        s_next.vprog[c] = s_next.vset[c];
        s_next.iprog[c] = s_next.iset[c];
      end else begin
        s_next.vprog[c] = 16'h0000;
        s_next.iprog[c] = oirc_pkg::OFF_CURRENT_MA;
      end
      // Line high for on+positive, inverted when off
      s_next.relay_pin[c] = ~(s_next.relay[c] ^ s_next.rpos[c]);
    end
    // Read data prepared in the setup cycle
    case (paddr)
      oirc_pkg::OFS_CTRL: begin
        hit = 1'b1;
        rd[oirc_pkg::CT_INH_LSB +: 2] = s_reg.ctrl.inh_mode;
        rd[oirc_pkg::CT_PAIR_LSB +: 2] = s_reg.ctrl.pair;
        rd[oirc_pkg::CT_TRACK] = s_reg.ctrl.track;
        rd[oirc_pkg::CT_MINMAX] = s_reg.ctrl.minmax;
        rd[oirc_pkg::CT_PON_LSB +: 4] = s_reg.ctrl.pon;
      end
      oirc_pkg::OFS_OUT: begin
        hit = 1'b1;
        rd[NCH-1:0] = s_reg.out_on;
        rd[oirc_pkg::OUT_REL_LSB +: NCH] = s_reg.relay;
        rd[oirc_pkg::OUT_POL_LSB +: NCH] = s_reg.rpos;
      end
      oirc_pkg::OFS_CLR: begin
        hit = 1'b1;
      end
      oirc_pkg::OFS_STAT: begin
        hit = 1'b1;
        rd[NCH-1:0] = s_reg.prot;
        rd[oirc_pkg::ST_INH_LAT] = s_reg.inh_lat;
        rd[oirc_pkg::ST_INH_LVL] = s_reg.inh_s2;
        rd[oirc_pkg::ST_EN_LSB +: NCH] = s_reg.en;
      end
      oirc_pkg::OFS_LOG: begin
        hit = 1'b1;
        rd[oirc_pkg::LOG_V_LSB +: NCH] = s_reg.vlog;
        rd[oirc_pkg::LOG_C_LSB +: NCH] = s_reg.clog;
      end
      default: begin
        if (hv[3]) begin
          hit = 1'b1;
          rd[15:0] = s_reg.vset[hv[2:0]];
        end else if (hi[3]) begin
          hit = 1'b1;
          rd[15:0] = s_reg.iset[hi[2:0]];
        end else if (hd[3]) begin
          hit = 1'b1;
          rd[21:0] = s_reg.dly[hd[2:0]];
        end
      end
    endcase
    // One access cycle: ready raised for the cycle after setup
    if (psel && !penable) begin
      s_next.pready = 1'b1;
      s_next.pslverr = ~hit;
      s_next.prdata = (hit && !pwrite) ? rd : 32'h0000_0000;
    end else begin
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;
      s_next.prdata = 32'h0000_0000;
    end
  end

  // ----------------
  // State register
  // ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ctrl.inh_mode <= oirc_pkg::INH_IGNORED;
      s_reg.rpos <= '1;
      s_reg.vset <= {NCH{oirc_pkg::RST_VSET}};
      s_reg.iset <= {NCH{oirc_pkg::RST_ISET}};
      s_reg.iprog <= {NCH{oirc_pkg::OFF_CURRENT_MA}};
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------
  // Outputs straight from the state register
  // ----------------
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign nv_save = s_reg.nv_save;
  assign nv_inhibit_mode = s_reg.ctrl.inh_mode;
  assign nv_pon_sel = s_reg.ctrl.pon;
  assign setup_default = s_reg.dflt;
  assign setup_recall = s_reg.recall;
  assign stored_setup_slot = s_reg.slot;
  assign ch_enable = s_reg.en;
  assign ch_vprog = s_reg.vprog;
  assign ch_iprog = s_reg.iprog;
  assign relay_ctrl = s_reg.relay_pin;
  assign volt_log_en = s_reg.vlog;
  assign curr_log_en = s_reg.clog;
  assign minmax_logging_enable = s_reg.ctrl.minmax;
  assign track_enable = s_reg.ctrl.track;
  assign pair_mode = s_reg.ctrl.pair;

endmodule // oirc_top

/* File: testbench/oirc_chk.sv */
`timescale 1ns/1ps
// ----------------
// Port checks on the output and inhibit block
// ----------------
module oirc_chk #(
  parameter int NCH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [oirc_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic inhibit_input,
  input wire logic [NCH-1:0] fault_trip,
  input wire logic [1:0] nv_inhibit_mode,
  input wire logic setup_default,
  input wire logic setup_recall,
  input wire logic [3:0] stored_setup_slot,
  input wire logic [NCH-1:0] ch_enable,
  input wire logic [NCH*16-1:0] ch_vprog,
  input wire logic [NCH*16-1:0] ch_iprog,
  input wire logic [NCH-1:0] relay_ctrl
);
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc; // Write access cycle
  logic wr_ctrl; // Write to the control word
  logic wr_out; // Write to the output word
  logic [2:0] quiet_reg; // Cycles since a legal cause of output loss
  assign acc = psel && penable && pwrite && pready;
  assign wr_ctrl = acc && paddr == oirc_pkg::OFS_CTRL;
  assign wr_out = acc && paddr == oirc_pkg::OFS_OUT;
  // Saturating count, restarted by output writes, faults, mode writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_reg <= 3'h0;
    end else if (wr_out || wr_ctrl || |fault_trip) begin
      quiet_reg <= 3'h0;
    end else if (quiet_reg != 3'h7) begin
      quiet_reg <= quiet_reg + 3'h1;
    end
  end
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("No answer after setup cycle");
  apb_single_a: assert property (pready |=> !pready)
    else $error("Ready held longer than one cycle");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("Error flag without ready");
  off_level_a: assert property (
    !ch_enable[0] && !$past(ch_enable[0]) |->
    ch_vprog[15:0] == 16'h0000 && ch_iprog[15:0] == oirc_pkg::OFF_CURRENT_MA)
    else $error("Disabled channel not at zero volts and off current");
  relay_cmd_a: assert property ($changed(relay_ctrl) |-> $past(wr_out))
    else $error("Relay line moved without relay write");
  live_cut_a: assert property (
    (nv_inhibit_mode == oirc_pkg::INH_LIVE && inhibit_input)[*6] |->
    ch_enable == '0)
    else $error("Live inhibit left an output on");
  latch_cut_a: assert property (
    (nv_inhibit_mode == oirc_pkg::INH_LATCHED && inhibit_input)[*6] |->
    ch_enable == '0)
    else $error("Latched inhibit left an output on");
  ignore_a: assert property (
    nv_inhibit_mode == oirc_pkg::INH_IGNORED && $fell(ch_enable[0]) |->
    quiet_reg < 3'h4)
    else $error("Output dropped with no cause in ignored mode");
  mode_src_a: assert property (
    $changed(nv_inhibit_mode) |-> $past(wr_ctrl) || !$past(presetn, 2))
    else $error("Stored inhibit mode changed on its own");
  power_up_a: assert property (
    $rose(presetn) |-> ##[1:3] (setup_default || setup_recall))
    else $error("No setup applied at power-up");
  slot_range_a: assert property (setup_recall |-> stored_setup_slot <= 4'h9)
    else $error("Recall slot out of range");
endmodule // oirc_chk

bind oirc_top oirc_chk #(.NCH(NCH)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .inhibit_input(inhibit_input), .fault_trip(fault_trip),
  .nv_inhibit_mode(nv_inhibit_mode), .setup_default(setup_default),
  .setup_recall(setup_recall), .stored_setup_slot(stored_setup_slot),
  .ch_enable(ch_enable), .ch_vprog(ch_vprog), .ch_iprog(ch_iprog),
  .relay_ctrl(relay_ctrl));

/* File: testbench/oirc_far_model.sv */
`timescale 1ns/1ps
// ----------------
// Inhibit source and external relay
// ----------------
module oirc_far_model #(
  parameter int NCH = 2
) (
  input wire logic inh_req,
  input wire logic [NCH-1:0] pol_pos,
  input wire logic [NCH-1:0] relay_ctrl,
  output logic inhibit_input,
  output logic [NCH-1:0] relay_closed
);
  initial inhibit_input = 1'b0;
  // Contact moves off the clock grid, so the sync sees it async
  always @(inh_req) begin
    inhibit_input <= #3 inh_req;
  end
  // Coil pulls in when the line sits at its active level
  assign relay_closed = ~(relay_ctrl ^ pol_pos);
endmodule // oirc_far_model

/* File: testbench/oirc_top_tb.sv */
`timescale 1ns/1ps
// ----------------
// Bench top
// ----------------
module oirc_top_tb;
  localparam int MS = 4; // Short millisecond
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic nv_save, setup_default, setup_recall, minmax_logging_enable;
  logic track_enable, front_panel_clear, inh_req, inhibit_input;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, ch_vprog, ch_iprog;
  logic [1:0] fault_trip, ch_enable, relay_ctrl, volt_log_en, curr_log_en;
  logic [1:0] pair_mode, nv_inhibit_mode, nv_inhibit_mode_in;
  logic [1:0] pol_pos, relay_closed;
  logic [3:0] nv_pon_sel_in, nv_pon_sel, stored_setup_slot, seen_slot;
  int bad_count, compares;
  int saves = 0; // Store pulses seen
  oirc_top #(.NCH(2), .MS_CYCLES(MS)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .inhibit_input(inhibit_input),
    .front_panel_clear(front_panel_clear), .fault_trip(fault_trip),
    .nv_inhibit_mode_in(nv_inhibit_mode_in), .nv_pon_sel_in(nv_pon_sel_in),
    .nv_save(nv_save), .nv_inhibit_mode(nv_inhibit_mode),
    .nv_pon_sel(nv_pon_sel), .setup_default(setup_default),
    .setup_recall(setup_recall), .stored_setup_slot(stored_setup_slot),
    .ch_enable(ch_enable), .ch_vprog(ch_vprog), .ch_iprog(ch_iprog),
    .relay_ctrl(relay_ctrl), .volt_log_en(volt_log_en),
    .curr_log_en(curr_log_en), .minmax_logging_enable(minmax_logging_enable),
    .track_enable(track_enable), .pair_mode(pair_mode));
  oirc_far_model #(.NCH(2)) i_far (.inh_req(inh_req), .pol_pos(pol_pos),
    .relay_ctrl(relay_ctrl), .inhibit_input(inhibit_input),
    .relay_closed(relay_closed));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Remember which slot power-up recalled
  always @(posedge pclk) begin
    if (setup_recall === 1'b1) seen_slot <= stored_setup_slot;
    if (nv_save === 1'b1) saves <= saves + 1;
  end
  // ----------------
  // Shared tasks
  // ----------------
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One bus transfer, held until ready, then released
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Bounded wait for a channel to reach a level
  task automatic wait_en(input int c, input logic v, output int n);
    n = 0;
    while (ch_enable[c] !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (ch_enable[c] !== v) begin
      bad_count++;
      wrap_up();
    end
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset();
    chk("nv mode", 32'(nv_inhibit_mode), 32'(oirc_pkg::INH_LIVE));
    chk("slot", 32'(seen_slot), 32'h2);
    chk("pon", 32'(nv_pon_sel), 32'h3);
    apb(1'b0, oirc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0000_0301);
    apb(1'b0, oirc_pkg::OFS_OUT, 32'h0);
    chk("out", rd, 32'h0003_0000);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped", 32'(err), 32'h1);
    $display("reset test done");
  endtask
  task automatic t_relay();
    logic [31:0] w;
    for (int k = 0; k < 4; k++) begin
      w = {14'h0, {2{k[1]}}, 6'h0, {2{k[0]}}, 8'h0};
      pol_pos <= {2{k[1]}};
      apb(1'b1, oirc_pkg::OFS_OUT, w);
      chk("closed", 32'(relay_closed), 32'({2{k[0]}}));
      chk("line", 32'(relay_ctrl), 32'({2{~(k[0] ^ k[1])}}));
      apb(1'b0, oirc_pkg::OFS_OUT, 32'h0);
      chk("relay rd", rd, w);
    end
    $display("relay test done");
  endtask
  task automatic t_prot();
    int n;
    apb(1'b1, oirc_pkg::OFS_VSET, 32'h1388);
    apb(1'b1, oirc_pkg::OFS_ISET, 32'h03e8);
    apb(1'b1, oirc_pkg::OFS_DLY, 32'h2);
    apb(1'b1, oirc_pkg::OFS_OUT, 32'h0003_0303);
    wait_en(0, 1'b1, n);
    chk("on delay", 32'(n >= 2 * MS - 2), 32'h1);
    wait_en(1, 1'b1, n);
    chk("vprog", 32'(ch_vprog[15:0]), 32'h1388);
    fault_trip <= 2'b01;
    @(posedge pclk);
    fault_trip <= 2'b00;
    wait_en(0, 1'b0, n);
    repeat (2) @(posedge pclk);
    chk("off v", 32'(ch_vprog[15:0]), 32'h0);
    chk("off i", 32'(ch_iprog[15:0]), 32'(oirc_pkg::OFF_CURRENT_MA));
    chk("other ch", 32'(ch_enable[1]), 32'h1);
    chk("relay kept", 32'(relay_ctrl), 32'h3);
    apb(1'b1, oirc_pkg::OFS_CLR, 32'h2);
    repeat (4) @(posedge pclk);
    chk("unlisted", 32'(ch_enable[0]), 32'h0);
    apb(1'b1, oirc_pkg::OFS_CLR, 32'h1);
    wait_en(0, 1'b1, n);
    chk("clr delay", 32'(n >= 2 * MS - 2), 32'h1);
    $display("protection test done");
  endtask
  task automatic t_inhibit();
    int n;
    apb(1'b1, oirc_pkg::OFS_DLY, 32'h0);
    apb(1'b1, oirc_pkg::OFS_OUT, 32'h0003_0301);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, oirc_pkg::OFS_CTRL, 32'(m));
      chk("mode", 32'(nv_inhibit_mode), 32'(m));
      inh_req <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("inh on", 32'(ch_enable), m == 2 ? 32'h1 : 32'h0);
      if (m == 0) apb(1'b1, oirc_pkg::OFS_CLR, 32'h100);
      inh_req <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("inh off", 32'(ch_enable), m == 0 ? 32'h0 : 32'h1);
      if (m == 0) begin
        apb(1'b0, oirc_pkg::OFS_STAT, 32'h0);
        chk("latch bit", 32'(rd[8]), 32'h1);
        front_panel_clear <= 1'b1;
        @(posedge pclk);
        front_panel_clear <= 1'b0;
        wait_en(0, 1'b1, n);
      end
    end
    apb(1'b1, oirc_pkg::OFS_CTRL, 32'h3);
    chk("bad mode", 32'(nv_inhibit_mode), 32'(oirc_pkg::INH_IGNORED));
    $display("inhibit test done");
  endtask
  task automatic t_track();
    apb(1'b1, oirc_pkg::OFS_OUT, 32'h0003_0300);
    apb(1'b1, oirc_pkg::OFS_VSET, 32'h0bb8);
    apb(1'b1, oirc_pkg::OFS_VSET + oirc_pkg::STRIDE_SET, 32'h0100);
    apb(1'b1, oirc_pkg::OFS_CTRL, 32'h32);
    apb(1'b0, oirc_pkg::OFS_VSET + oirc_pkg::STRIDE_SET, 32'h0);
    chk("track copy", rd, 32'h0bb8);
    apb(1'b1, oirc_pkg::OFS_VSET + oirc_pkg::STRIDE_SET, 32'h07d0);
    apb(1'b0, oirc_pkg::OFS_VSET, 32'h0);
    chk("track mirror", rd, 32'h07d0);
    chk("minmax", {track_enable, minmax_logging_enable}, 32'h3);
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, oirc_pkg::OFS_CTRL, 32'h2 | 32'(p << 2));
      chk("pair", 32'(pair_mode), 32'(p));
    end
    apb(1'b1, oirc_pkg::OFS_LOG, 32'h0201);
    chk("log pins", {curr_log_en, volt_log_en}, 32'h9);
    apb(1'b0, oirc_pkg::OFS_LOG, 32'h0);
    chk("log rd", rd, 32'h0201);
    chk("saves", 32'(saves), 32'h3);
    $display("track and log test done");
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    inh_req = 1'b0;
    pol_pos = 2'h3;
    front_panel_clear = 1'b0;
    fault_trip = 2'h0;
    nv_inhibit_mode_in = oirc_pkg::INH_LIVE;
    nv_pon_sel_in = 4'h3;
    seen_slot = 4'hf;
    bad_count = 0;
    compares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_relay();
    t_prot();
    t_inhibit();
    t_track();
    wrap_up();
  end
endmodule // oirc_top_tb
